// ===== addr485_map.svh
`ifndef ADDR485_MAP_SVH
`define ADDR485_MAP_SVH

// Clock and bit timing
`define MCLK_HZ      100000000
`define BAUD_MIN     1200
`define BIT_CLKS_MIN (`MCLK_HZ / `BAUD_MIN)
`define WAKE_CYCLES  2'h3

// Factory settings
`define DEF_BAUD     3'h5
`define DEF_FMT      2'h1
`define DEF_ADDR     8'h01
`define DEF_WIRE     2'h2

// Setup menu groups and value ranges
`define GRP_ENTRY    3'h1
`define GRP_BAUD     3'h2
`define GRP_FMT      3'h3
`define GRP_ADDR     3'h4
`define GRP_WIRE     3'h5
`define VAL_MIN      8'h01
`define BAUD_MAX     8'h05
`define FMT_MAX      8'h03
`define ADDR_MAX     8'hFF
`define WIRE_MAX     8'h02

// Field codes
`define FMT_8N1      2'h1
`define FMT_7O1      2'h2
`define FMT_7E1      2'h3
`define WIRE_TWO     2'h1

// Characters and reply layout
`define CH_START     8'h23
`define CH_CR        8'h0D
`define CH_ACK       8'h2A
`define CH_NAK       8'h3F
`define REPLY_DATA0  5'h03
`define REPLY_DATAN  5'h0F
`define REPLY_CR     5'h10
`define REPLY_END    5'h11
`define FRAME_LAST   4'h9
`define FIFO_DEPTH   32

`endif

// ===== addr485_pkg.sv
package addr485_pkg;

    // Serial port settings as stored and as applied
    typedef struct packed {
        logic [2:0] baud;
        logic [1:0] fmt;
        logic [7:0] addr;
        logic [1:0] wire_mode;
    } port_cfg_t;

    // One command character handed to the gauge core
    typedef struct packed {
        logic       last;
        logic       bad;
        logic [7:0] ch;
    } cmd_word_t;

    typedef enum logic [2:0] {
        ps_idle, ps_addr_hi, ps_addr_lo, ps_data, ps_skip, ps_term
    } parse_state_t;

endpackage

// ===== addressed_rs485_command_port.sv
// What this block does
// - Factory settings run the port at 19200 baud, 8 data bits, no parity, 1 stop.
// - Factory node address is 01 hex and wiring is four-wire.
// - Up and down held at power-up enter the setup menu, not normal operation.
// - Each calibrate press advances the shown group, 2 baud through 5 wiring.
// - Baud readouts 1 to 5 select 1200, 2400, 4800, 9600, 19200.
// - Format readouts 1 to 3 select 8N1, 7O1, 7E1.
// - Address readouts select node address 01 to FF hex.
// - Wiring readout 1 selects two-wire, readout 2 four-wire.
// - Calibrate press commits the shown group value to non-volatile storage.
// - Stored settings apply only after the next power cycle.
// - Two-wire mode receives and transmits on one shared pair.
// - Four-wire mode receives on one pair, transmits on another.
// - Address compare first, then command data check; act and answer only on match.
// - One direction at a time per pair; transmit only while the receive line is idle.
// - Address field is two ASCII hex characters.
// - Reply data field holds exactly 13 upper-case characters.
// - Malformed command gets a syntax-error reply carrying the own address.
`timescale 1ns/10ps
`default_nettype none
`include "addr485_map.svh"

// Command FIFO between the line parser and the gauge core
module cmd_fifo #(
    parameter int W     = 10,
    parameter int DEPTH = 32
) (
    input  wire logic         mclk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr_reg;
    logic [AW:0]  rd_ptr_reg;
    wire          full_w  = (wr_ptr_reg[AW] != rd_ptr_reg[AW])
                            && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    wire          empty_w = (wr_ptr_reg == rd_ptr_reg);

    // Handshakes and head word
    assign in_ready  = !full_w;
    assign out_valid = !empty_w;
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];

    // Storage
    always_ff @(posedge mclk) begin
        if (in_valid && !full_w)
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end

    // Pointers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (in_valid && !full_w)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (out_ready && !empty_w)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule

module addressed_rs485_command_port
    import addr485_pkg::*;
#(
    parameter int unsigned BIT_CLKS_MIN = `BIT_CLKS_MIN,
    parameter int          FIFO_DEPTH   = `FIFO_DEPTH
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       key_up,
    input  wire logic       key_down,
    input  wire logic       key_cal,
    input  wire port_cfg_t  nv_cfg,
    input  wire logic       nv_blank,
    output logic            nv_wr,
    output port_cfg_t       nv_wr_cfg,
    output logic            setup_active,
    output logic [2:0]      disp_group,
    output logic [7:0]      disp_value,
    output port_cfg_t       active_cfg,
    input  wire logic       rx_pair,
    output logic            tx_pair_o,
    output logic            tx_pair_oe_n,
    input  wire logic       bus_i,
    output logic            bus_o,
    output logic            bus_oe_n,
    output logic            cmd_valid,
    input  wire logic       cmd_ready,
    output cmd_word_t       cmd_word,
    input  wire logic       rsp_valid,
    output logic            rsp_ready,
    input  wire logic [7:0] rsp_char
);
    localparam int CW = $clog2(BIT_CLKS_MIN + 1);
    localparam port_cfg_t CFG_DEF = '{baud: `DEF_BAUD, fmt: `DEF_FMT,
                                      addr: `DEF_ADDR, wire_mode: `DEF_WIRE};

    function automatic logic [CW-1:0] bit_clks(input logic [2:0] b);
        case (b)
            3'h1:    return CW'(BIT_CLKS_MIN);
            3'h2:    return CW'(BIT_CLKS_MIN / 2);
            3'h3:    return CW'(BIT_CLKS_MIN / 4);
            3'h4:    return CW'(BIT_CLKS_MIN / 8);
            default: return CW'(BIT_CLKS_MIN / 16);
        endcase
    endfunction

    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39)
            return {1'b1, c[3:0]};
        if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
            return {1'b1, c[3:0] + 4'h9};
        return 5'h00;
    endfunction

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    function automatic logic [7:0] nak_char(input logic [3:0] i);
        case (i)
            4'h1:       return 8'h53;
            4'h2:       return 8'h59;
            4'h3:       return 8'h4E;
            4'h4:       return 8'h54;
            4'h5:       return 8'h58;
            4'h7:       return 8'h45;
            4'h8, 4'h9: return 8'h52;
            4'hA:       return 8'h4F;
            4'hB:       return 8'h52;
            default:    return 8'h5F;
        endcase
    endfunction

    function automatic logic [9:0] frame(input logic [7:0] c, input logic [1:0] f);
        logic p;
        p = ^c[6:0];
        case (f)
            `FMT_7O1: return {1'b1, ~p, c[6:0], 1'b0};
            `FMT_7E1: return {1'b1, p, c[6:0], 1'b0};
            default:  return {1'b1, c, 1'b0};
        endcase
    endfunction

    function automatic logic [7:0] cfg_field(input port_cfg_t c, input logic [2:0] g);
        case (g)
            `GRP_BAUD: return {5'h00, c.baud};
            `GRP_FMT:  return {6'h00, c.fmt};
            `GRP_ADDR: return c.addr;
            `GRP_WIRE: return {6'h00, c.wire_mode};
            default:   return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] val_max(input logic [2:0] g);
        case (g)
            `GRP_BAUD: return `BAUD_MAX;
            `GRP_FMT:  return `FMT_MAX;
            `GRP_ADDR: return `ADDR_MAX;
            `GRP_WIRE: return `WIRE_MAX;
            default:   return 8'h00;
        endcase
    endfunction

    // Pin synchronisers, second stages only are read
    logic [4:0] s1_reg;
    logic [4:0] s2_reg;
    logic [2:0] key_d_reg;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_reg    <= 5'h03;
            s2_reg    <= 5'h03;
            key_d_reg <= 3'h0;
        end else begin
            s1_reg    <= {key_cal, key_down, key_up, bus_i, rx_pair};
            s2_reg    <= s1_reg;
            key_d_reg <= s2_reg[4:2];
        end
    end
    wire [2:0] key_p = s2_reg[4:2] & ~key_d_reg;

    // Startup capture, setup menu and committed settings
    logic [1:0] wake_reg;
    logic       started_reg;
    logic       setup_reg;
    port_cfg_t  cfg_reg;
    port_cfg_t  edit_reg;
    port_cfg_t  edit_next;
    logic [2:0] grp_reg;
    logic [2:0] grp_next;
    logic [7:0] val_reg;
    logic [7:0] val_next;
    logic       wr_reg;
    wire        wake_now = !started_reg && (wake_reg == `WAKE_CYCLES);
    wire        run      = started_reg && !setup_reg;
    wire        four     = (cfg_reg.wire_mode != `WIRE_TWO);

    // Menu editing: clamp at range ends, commit and advance on calibrate
    always_comb begin
        edit_next = edit_reg;
        grp_next  = grp_reg;
        val_next  = val_reg;
        if (setup_reg && key_p[2]) begin
            case (grp_reg)
                `GRP_BAUD: edit_next.baud      = val_reg[2:0];
                `GRP_FMT:  edit_next.fmt       = val_reg[1:0];
                `GRP_ADDR: edit_next.addr      = val_reg;
                `GRP_WIRE: edit_next.wire_mode = val_reg[1:0];
                default:   edit_next           = edit_reg;
            endcase
            grp_next = (grp_reg == `GRP_WIRE || grp_reg == `GRP_ENTRY)
                       ? `GRP_BAUD : grp_reg + 3'h1;
            val_next = cfg_field(edit_next, grp_next);
        end else if (setup_reg && key_p[0] && val_reg < val_max(grp_reg)) begin
            val_next = val_reg + 8'h01;
        end else if (setup_reg && key_p[1] && val_reg > `VAL_MIN) begin
            val_next = val_reg - 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wake_reg    <= 2'h0;
            started_reg <= 1'b0;
            setup_reg   <= 1'b0;
            cfg_reg     <= CFG_DEF;
            edit_reg    <= CFG_DEF;
            grp_reg     <= `GRP_ENTRY;
            val_reg     <= 8'h00;
            wr_reg      <= 1'b0;
        end else if (!started_reg) begin
            wake_reg <= wake_reg + 2'h1;
            if (wake_now) begin
                started_reg <= 1'b1;
                setup_reg   <= s2_reg[2] & s2_reg[3];
                cfg_reg     <= nv_blank ? CFG_DEF : nv_cfg;
                edit_reg    <= nv_blank ? CFG_DEF : nv_cfg;
            end
        end else begin
            edit_reg <= edit_next;
            grp_reg  <= grp_next;
            val_reg  <= val_next;
            wr_reg   <= setup_reg && key_p[2] && grp_reg != `GRP_ENTRY;
        end
    end

    assign nv_wr        = wr_reg;
    assign nv_wr_cfg    = edit_reg;
    assign setup_active = setup_reg;
    assign disp_group   = grp_reg;
    assign disp_value   = val_reg;
    assign active_cfg   = cfg_reg;

    // Receiver: wiring picks the pair, 10-bit frame for every format
    logic          rx_busy_reg;
    logic [CW-1:0] rx_cnt_reg;
    logic [3:0]    rx_idx_reg;
    logic [7:0]    rx_sh_reg;
    logic          rx_stb_reg;
    logic          rx_err_reg;
    logic          reply_active_reg;
    wire [CW-1:0]  div     = bit_clks(cfg_reg.baud);
    wire           rx_line = four ? s2_reg[0] : s2_reg[1];
    wire           par_bad = (cfg_reg.fmt == `FMT_7O1) ? ~(^rx_sh_reg)
                           : (cfg_reg.fmt == `FMT_7E1) ? ^rx_sh_reg : 1'b0;
    wire [7:0]     rx_char = (cfg_reg.fmt == `FMT_7O1 || cfg_reg.fmt == `FMT_7E1)
                           ? {1'b0, rx_sh_reg[6:0]} : rx_sh_reg;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_busy_reg <= 1'b0;
            rx_cnt_reg  <= '0;
            rx_idx_reg  <= 4'h0;
            rx_sh_reg   <= 8'h00;
            rx_stb_reg  <= 1'b0;
            rx_err_reg  <= 1'b0;
        end else begin
            rx_stb_reg <= 1'b0;
            if (!run || reply_active_reg) begin
                rx_busy_reg <= 1'b0;
            end else if (!rx_busy_reg) begin
                rx_busy_reg <= !rx_line;
                rx_cnt_reg  <= div >> 1;
                rx_idx_reg  <= 4'h0;
            end else if (rx_cnt_reg != '0) begin
                rx_cnt_reg <= rx_cnt_reg - 1'b1;
            end else begin
                rx_cnt_reg <= div - 1'b1; // Zero state counts, so reload one short
                rx_idx_reg <= rx_idx_reg + 4'h1;
                if (rx_idx_reg == 4'h0 && rx_line)
                    rx_busy_reg <= 1'b0;
                else if (rx_idx_reg != `FRAME_LAST)
                    rx_sh_reg <= {rx_line, rx_sh_reg[7:1]};
                else begin
                    rx_busy_reg <= 1'b0;
                    rx_stb_reg  <= 1'b1;
                    rx_err_reg  <= !rx_line || par_bad;
                end
            end
        end
    end

    // Command parser: start character, own address, data up to CR
    parse_state_t p_reg;
    parse_state_t p_next;
    logic [3:0]   hi_reg;
    logic [3:0]   hi_next;
    logic         err_reg;
    logic         err_next;
    logic         pv_reg;
    logic         pv_next;
    cmd_word_t    pw_reg;
    cmd_word_t    pw_next;
    logic         nak_reg;
    logic         nak_set;
    logic         fifo_in_ready;
    logic         start_ok;
    wire [4:0]    hx = hex_val(rx_char);

    always_comb begin
        p_next   = p_reg;
        hi_next  = hi_reg;
        err_next = err_reg;
        pv_next  = pv_reg && !fifo_in_ready;
        pw_next  = pw_reg;
        nak_set  = 1'b0;
        if (p_reg == ps_term && !pv_next) begin
            pv_next = 1'b1;
            pw_next = '{last: 1'b1, bad: err_reg, ch: `CH_CR};
            nak_set = err_reg;
            p_next  = ps_idle;
        end
        if (rx_stb_reg && !rx_err_reg && rx_char == `CH_START) begin
            p_next   = ps_addr_hi;
            err_next = 1'b0;
        end else if (rx_stb_reg) begin
            unique case (p_reg)
                ps_idle, ps_skip, ps_term: ;
                ps_addr_hi: begin
                    hi_next = hx[3:0];
                    p_next  = hx[4] ? ps_addr_lo : ps_idle;
                end
                ps_addr_lo: begin
                    if (!hx[4])
                        p_next = ps_idle;
                    else if ({hi_reg, hx[3:0]} == cfg_reg.addr)
                        p_next = ps_data;
                    else
                        p_next = ps_skip;
                end
                ps_data: begin
                    if (rx_err_reg)
                        err_next = 1'b1;
                    else if (rx_char == `CH_CR)
                        p_next = ps_term;
                    else if (pv_next)
                        err_next = 1'b1;
                    else if (!err_reg) begin
                        pv_next = 1'b1;
                        pw_next = '{last: 1'b0, bad: 1'b0, ch: rx_char};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            p_reg   <= ps_idle;
            hi_reg  <= 4'h0;
            err_reg <= 1'b0;
            pv_reg  <= 1'b0;
            pw_reg  <= '0;
            nak_reg <= 1'b0;
        end else begin
            p_reg   <= p_next;
            hi_reg  <= hi_next;
            err_reg <= err_next;
            pv_reg  <= pv_next;
            pw_reg  <= pw_next;
            nak_reg <= nak_set || (nak_reg && !start_ok);
        end
    end

    cmd_fifo #(
        .W     ($bits(cmd_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .nrst      (nrst),
        .in_valid  (pv_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (pw_reg),
        .out_valid (cmd_valid),
        .out_ready (cmd_ready),
        .out_data  (cmd_word)
    );

    // Reply sequencer: mark, address, 13 data characters, CR
    logic          nak_kind_reg;
    logic [4:0]    byte_reg;
    logic          drv_reg;
    logic          tx_busy_reg;
    logic [CW-1:0] tx_cnt_reg;
    logic [3:0]    tx_idx_reg;
    logic [9:0]    tx_sh_reg;
    logic          txd_reg;
    logic [7:0]    tx_byte;
    wire           data_ph = byte_reg >= `REPLY_DATA0 && byte_reg <= `REPLY_DATAN;
    wire           load    = reply_active_reg && !tx_busy_reg && byte_reg != `REPLY_END
                             && (!data_ph || nak_kind_reg || rsp_valid);
    wire           done    = reply_active_reg && !tx_busy_reg && byte_reg == `REPLY_END;

    assign start_ok  = run && !reply_active_reg && !rx_busy_reg && rx_line
                       && (nak_reg || rsp_valid);
    assign rsp_ready = load && data_ph && !nak_kind_reg;

    always_comb begin
        if (byte_reg == 5'h00)
            tx_byte = nak_kind_reg ? `CH_NAK : `CH_ACK;
        else if (byte_reg == 5'h01)
            tx_byte = hex_char(cfg_reg.addr[7:4]);
        else if (byte_reg == 5'h02)
            tx_byte = hex_char(cfg_reg.addr[3:0]);
        else if (byte_reg == `REPLY_CR)
            tx_byte = `CH_CR;
        else if (nak_kind_reg)
            tx_byte = nak_char(4'(byte_reg - `REPLY_DATA0));
        else
            tx_byte = rsp_char;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reply_active_reg <= 1'b0;
            nak_kind_reg     <= 1'b0;
            byte_reg         <= 5'h00;
            drv_reg          <= 1'b0;
        end else if (start_ok) begin
            reply_active_reg <= 1'b1;
            nak_kind_reg     <= nak_reg;
            byte_reg         <= 5'h00;
            drv_reg          <= 1'b1;
        end else if (load) begin
            byte_reg <= byte_reg + 5'h01;
        end else if (done) begin
            reply_active_reg <= 1'b0;
            drv_reg          <= 1'b0;
        end
    end

    // Transmitter bit timing
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_busy_reg <= 1'b0;
            tx_cnt_reg  <= '0;
            tx_idx_reg  <= 4'h0;
            tx_sh_reg   <= 10'h3FF;
            txd_reg     <= 1'b1;
        end else if (load) begin
            tx_busy_reg <= 1'b1;
            tx_sh_reg   <= frame(tx_byte, cfg_reg.fmt);
            txd_reg     <= 1'b0;
            tx_cnt_reg  <= div - 1'b1;
            tx_idx_reg  <= 4'h0;
        end else if (tx_busy_reg && tx_cnt_reg != '0) begin
            tx_cnt_reg <= tx_cnt_reg - 1'b1;
        end else if (tx_busy_reg) begin
            tx_cnt_reg  <= div - 1'b1;
            tx_idx_reg  <= tx_idx_reg + 4'h1;
            tx_sh_reg   <= tx_sh_reg >> 1;
            txd_reg     <= tx_idx_reg == `FRAME_LAST ? 1'b1 : tx_sh_reg[1];
            tx_busy_reg <= tx_idx_reg != `FRAME_LAST;
        end
    end

    // Driver enables pick the transmit pair
    assign tx_pair_o    = txd_reg;
    assign bus_o        = txd_reg;
    assign tx_pair_oe_n = !(drv_reg && four);
    assign bus_oe_n     = !(drv_reg && !four);

    AST_DRV_QUIET: assert property (@(posedge mclk) disable iff (!nrst)
        !reply_active_reg |-> tx_pair_oe_n && bus_oe_n)
        else $error("line driver enabled outside a reply");
    AST_ONE_PAIR: assert property (@(posedge mclk) disable iff (!nrst)
        !(tx_pair_oe_n == 1'b0 && bus_oe_n == 1'b0))
        else $error("both pairs driven");
    AST_SETUP_SILENT: assert property (@(posedge mclk) disable iff (!nrst)
        setup_reg |-> !reply_active_reg && !pv_reg)
        else $error("serial activity in setup menu");
    AST_CFG_HELD: assert property (@(posedge mclk) disable iff (!nrst)
        started_reg && $past(started_reg) |-> $stable(cfg_reg))
        else $error("applied settings changed after startup");
    AST_FACTORY: assert property (@(posedge mclk) disable iff (!nrst)
        wake_now && nv_blank |=> cfg_reg == CFG_DEF && started_reg)
        else $error("factory settings not applied");
    AST_COMMIT: assert property (@(posedge mclk) disable iff (!nrst)
        started_reg && setup_reg && key_p[2] && grp_reg == `GRP_ADDR
        |=> nv_wr && nv_wr_cfg.addr == $past(val_reg))
        else $error("calibrate did not commit shown value");
    AST_GROUP_WRAP: assert property (@(posedge mclk) disable iff (!nrst)
        started_reg && setup_reg && key_p[2] && grp_reg == `GRP_WIRE
        |=> grp_reg == `GRP_BAUD)
        else $error("group did not wrap to baud");
    AST_MATCH_ONLY: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(pv_reg) |-> $past(p_reg) == ps_data || $past(p_reg) == ps_term)
        else $error("command pushed without address match");
    AST_QUIET_LINE: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(reply_active_reg) |-> !$past(rx_busy_reg) && $past(rx_line))
        else $error("reply started while line busy");
    AST_NAK_MARK: assert property (@(posedge mclk) disable iff (!nrst)
        load && byte_reg == 5'h00 && nak_kind_reg |=> tx_sh_reg == frame(`CH_NAK, cfg_reg.fmt))
        else $error("syntax reply without error mark");
endmodule
`default_nettype wire

// ===== host_line.sv
`timescale 1ns/10ps
`default_nettype none

// Host computer on either wiring (drives rx_pair and bus_i): sends commands, reads replies
module host_line #(
    parameter int BIT = 10
) (
    input  wire logic mclk,
    input  wire logic dev_tx,
    input  wire logic dev_oe_n,
    output logic      host_tx
);
    initial host_tx = 1'b1;

    // One frame: start, eight data bits LSB first, stop; line idles high
    task automatic send(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            host_tx = f[i];
            repeat (BIT) @(negedge mclk);
        end
    endtask

    // Waits for a start bit from an enabled driver, samples mid-bit
    task automatic recv(output logic [7:0] c, output bit ok);
        int n;
        n = 0;
        c = 8'h00;
        while (!(dev_oe_n === 1'b0 && dev_tx === 1'b0) && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        ok = (n < 20000);
        repeat (BIT / 2) @(negedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(negedge mclk);
            c[i] = dev_tx;
        end
        repeat (BIT) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// ===== tb_addressed_rs485_command_port.sv
`timescale 1ns/10ps
`default_nettype none

module tb_addressed_rs485_command_port;
    import addr485_pkg::*;
    logic mclk, nrst, key_up, key_down, key_cal, nv_wr, setup_active, rx_pair, tx_pair_o;
    logic tx_pair_oe_n, bus_o, bus_oe_n, cmd_valid, rsp_valid, rsp_ready;
    logic [2:0] disp_group;
    logic [7:0] disp_value, rsp_char;
    logic nv_blank;
    port_cfg_t  nv_wr_cfg, active_cfg, wr_cfg, nv_cfg;
    cmd_word_t  cmd_word;
    cmd_word_t  cmdq[$];
    int failures, checked, n_rsp, n_drv, n_wr, n_bus;
    // Host sees whichever pair the device drives
    wire logic dev_oe_n = tx_pair_oe_n & bus_oe_n;
    wire logic dev_tx   = tx_pair_oe_n ? bus_o : tx_pair_o;

    addressed_rs485_command_port #(.BIT_CLKS_MIN(160)) i_addressed_rs485_command_port (
        .mclk(mclk), .nrst(nrst), .key_up(key_up), .key_down(key_down), .key_cal(key_cal),
        .nv_cfg(nv_cfg), .nv_blank(nv_blank), .nv_wr(nv_wr), .nv_wr_cfg(nv_wr_cfg),
        .setup_active(setup_active), .disp_group(disp_group), .disp_value(disp_value),
        .active_cfg(active_cfg), .rx_pair(rx_pair), .tx_pair_o(tx_pair_o),
        .tx_pair_oe_n(tx_pair_oe_n), .bus_i(rx_pair), .bus_o(bus_o), .bus_oe_n(bus_oe_n),
        .cmd_valid(cmd_valid), .cmd_ready(1'b1), .cmd_word(cmd_word),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_char(rsp_char));
    host_line #(.BIT(10)) i_host_line (
        .mclk(mclk), .dev_tx(dev_tx), .dev_oe_n(dev_oe_n), .host_tx(rx_pair));

    always #5 mclk = ~mclk;

    // Records core-side words, reply chars, driver cycles and stores
    always @(posedge mclk) begin
        if (cmd_valid === 1'b1) cmdq.push_back(cmd_word);
        if (rsp_valid && rsp_ready === 1'b1) n_rsp++;
        if (tx_pair_oe_n === 1'b0) n_drv++;
        if (bus_oe_n === 1'b0) n_bus++;
        if (nv_wr === 1'b1) begin
            n_wr++;
            wr_cfg = nv_wr_cfg;
        end
    end

    // Core hands over exactly 13 reply chars
    always @(negedge mclk) if (n_rsp == 13) rsp_valid = 1'b0;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_sim();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic do_reset(input logic keys);
        nrst = 1'b0;
        key_up = keys;
        key_down = keys;
        repeat (5) @(negedge mclk);
        nrst = 1'b1;
        repeat (10) @(negedge mclk);
        key_up = 1'b0;
        key_down = 1'b0;
        repeat (4) @(negedge mclk);
    endtask

    task automatic press(ref logic k);
        k = 1'b1;
        repeat (6) @(negedge mclk);
        k = 1'b0;
        repeat (6) @(negedge mclk);
    endtask

    task automatic send_str(input string s);
        for (int i = 0; i < s.len(); i++) i_host_line.send(s[i]);
    endtask

    // Own address: words reach the core, reply is mark, address, 13 chars, CR
    task automatic own_cmd();
        logic [7:0] c, e;
        bit ok;
        cmdq.delete();
        n_rsp = 0;
        send_str("#01RD\r");
        repeat (20) @(negedge mclk);
        chk("words", 3, 32'(cmdq.size()));
        chk("last", 32'h20D, 32'(cmdq[cmdq.size() - 1]));
        rsp_valid = 1'b1;
        for (int i = 0; i < 17; i++) begin
            i_host_line.recv(c, ok);
            if (!ok) begin
                failures++;
                end_sim();
            end
            e = (i == 0) ? 8'h2A : (i == 1) ? 8'h30 : (i == 2) ? 8'h31 : (i == 16) ? 8'h0D : 8'h41;
            chk("reply", 32'(e), 32'(c));
        end
        repeat (30) @(negedge mclk);
        chk("oe_n", 1, 32'(dev_oe_n));
    endtask

    // Foreign address: nothing for the core, driver never enabled
    task automatic other_cmd();
        cmdq.delete();
        n_drv = 0;
        send_str("#02RD\r");
        repeat (300) @(negedge mclk);
        chk("words", 0, 32'(cmdq.size()));
        chk("drive", 0, 32'(n_drv));
    endtask

    // Setup menu: baud group shown, up at max refused, calibrate stores
    task automatic setup_menu();
        chk("setup", 1, 32'(setup_active));
        press(key_cal);
        chk("group", 2, 32'(disp_group));
        press(key_up);
        chk("value", 5, 32'(disp_value));
        press(key_down);
        press(key_cal);
        chk("stores", 1, 32'(n_wr));
        chk("baud", 4, 32'(wr_cfg.baud));
        chk("group", 3, 32'(disp_group));
        chk("live", 5, 32'(active_cfg.baud));
        press(key_cal);
        press(key_up);
        press(key_cal);
        chk("addr", 2, 32'(wr_cfg.addr));
        press(key_cal);
        chk("group", 2, 32'(disp_group));
    endtask

    // Stored two-wire settings apply at power-up, reply leaves on the shared pair
    task automatic stored_cfg();
        nv_blank = 1'b0;
        nv_cfg = 15'h5405;
        do_reset(1'b0);
        chk("cfg", 32'h5405, 32'(active_cfg));
        n_drv = 0;
        own_cmd();
        chk("pair", 0, 32'(n_drv));
    endtask

    initial begin
        mclk = 1'b0;
        key_cal = 1'b0;
        rsp_valid = 1'b0;
        rsp_char = 8'h41;
        {failures, checked, n_wr} = '0;
        nv_blank = 1'b1;
        nv_cfg = 15'h0000;
        do_reset(1'b0);
        chk("cfg", 32'(15'h5406), 32'(active_cfg));
        chk("setup", 0, 32'(setup_active));
        own_cmd();
        chk("bus", 0, 32'(n_bus));
        other_cmd();
        stored_cfg();
        do_reset(1'b1);
        setup_menu();
        end_sim();
    end
endmodule
`default_nettype wire
